// ### include/ltm_defines.svh
// Constants for the slow-oscillator capture and split timer block.
// Assumes inclusion by bare name from every design file.
`ifndef LTM_DEFINES_SVH
`define LTM_DEFINES_SVH

// ----------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------
`define LTM_ADDR_T3_RELOAD_LOW 8'h92
`define LTM_ADDR_T3_RELOAD_HIGH 8'h93
`define LTM_ADDR_T3_COUNT_LOW 8'h94
`define LTM_ADDR_T2_RELOAD_LOW 8'hca
`define LTM_ADDR_T2_RELOAD_HIGH 8'hcb
`define LTM_ADDR_T2_COUNT_LOW 8'hcc

// ----------------------------------------------------------------
// Values
// ----------------------------------------------------------------
`define LTM_RESET_BYTE 8'h00
`define LTM_BYTE_MAX 8'hff
`define LTM_BYTE_ONE 8'h01
`define LTM_UNMAPPED_READ 8'h00

// ----------------------------------------------------------------
// Prescalers: system clock / 12, external clock / 8
// ----------------------------------------------------------------
`define LTM_DIV12_ZERO 4'h0
`define LTM_DIV12_ONE 4'h1
`define LTM_DIV12_LAST 4'hb
`define LTM_EXT8_ZERO 3'h0
`define LTM_EXT8_ONE 3'h1
`define LTM_EXT8_LAST 3'h7

`endif

// ### include/ltm_pkg.sv
// Types shared by the capture and split timer block.
// Assumes nothing beyond a SystemVerilog compiler.
package ltm_pkg;

  typedef logic [7:0] ltm_byte_t;

  // Alternate clock field of the Timer 3 counters
  typedef enum logic [1:0]
  {
    LTM_XCLK_DIV12 = 2'b00,
    LTM_XCLK_EXT8 = 2'b01,
    LTM_XCLK_RSVD = 2'b10,
    LTM_XCLK_SLOW = 2'b11
  } ltm_xclk_t;

endpackage

// ### include/ltm_cnt_if.sv
// Carrier between the timer control logic and one 8-bit counter.
// Assumes the package is compiled first.
`timescale 1ns/1ps
interface ltm_cnt_if;
  import ltm_pkg::*;
  logic inc;
  logic reloadNow;
  ltm_byte_t reloadVal;
  logic wrEn;
  ltm_byte_t wrData;
  ltm_byte_t count;
  logic atMax;

  modport ctl
  (
    output inc, reloadNow, reloadVal, wrEn, wrData,
    input count, atMax
  );
  modport cnt
  (
    input inc, reloadNow, reloadVal, wrEn, wrData,
    output count, atMax
  );
endinterface

// ### logic/ltm_counter8.sv
// One 8-bit counter byte with software load and reload.
// Assumes the control side gives at most one increment per cycle.
`timescale 1ns/1ps
`include "ltm_defines.svh"
module ltm_counter8
(
  input wire logic sys_clk,
  input wire logic reset_n,
  ltm_cnt_if.cnt port
);
  import ltm_pkg::*;

  ltm_byte_t countReg;
  ltm_byte_t countNext;

  // Software write beats a tick in the same cycle
  always_comb
  begin
    countNext = countReg;
    if (port.wrEn)
    begin
      countNext = port.wrData;
    end
    else if (port.inc)
    begin
      if (port.reloadNow)
      begin
        countNext = port.reloadVal;
      end
      else
      begin
        countNext = countReg + `LTM_BYTE_ONE;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      countReg <= `LTM_RESET_BYTE;
    else
      countReg <= countNext;
  end

  assign port.count = countReg;
  assign port.atMax = (countReg == `LTM_BYTE_MAX);

  a_load_wins : assert property (@(posedge sys_clk) disable iff (!reset_n)
    port.wrEn |=> countReg == $past(port.wrData))
    else $error("Counter load lost");
endmodule

// ### logic/ltm_timers.sv
// Timer 2 with slow-oscillator capture and Timer 3 with split mode.
// Assumes software drives the register port and the control pins;
// oscillator inputs are levels sampled on the system clock.
//
// Operation
// - Timer 2 ticks on system clock, system clock /12 or external /8.
// - Capture-enable bit set puts Timer 2 into slow-oscillator capture.
// - Slow-oscillator falling edge copies Timer 2 count to reloads, sets flag.
// - Timer 2 low count is 16-bit low byte or whole 8-bit low timer.
// - Timer 3 split gives two 8-bit timers, each reloading its own byte.
// - In split, run bit gates only high byte; low byte always counts.
// - Timer 3 high clock in split: system clock, or field selects /12, ext/8, slow.
// - Timer 3 low clock chosen the same way with its own select bit.
// - Timer 3 flags set on their byte reloading from ff; low flag in split only.
// - With Timer 3 interrupts on, each high overflow requests interrupt.
// - With low enable too, either byte overflow requests interrupt.
// - Hardware never clears Timer 3 flags; software clears them.
// - Timer 2 reload bytes are read-write and reset to zero.
// - Timer 3 reload bytes are read-write and reset to zero.
// - Timer 3 low count is read-write, resets to zero.
`timescale 1ns/1ps
`include "ltm_defines.svh"
module ltm_timers
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire ltm_pkg::ltm_byte_t sfrAddr,
  input wire logic sfrWrEn,
  input wire ltm_pkg::ltm_byte_t sfrWrData,
  input wire logic sfrRdEn,
  output ltm_pkg::ltm_byte_t sfrRdData,
  input wire logic extOscIn,
  input wire logic slowOscIn,
  input wire logic t2RunControl,
  input wire logic t2LowClockSelect,
  input wire logic t2AltClockSelect,
  input wire logic t2CaptureEnable,
  input wire logic t2SplitSelect,
  input wire logic t2HighFlagClear,
  output logic t2HighFlag,
  output ltm_pkg::ltm_byte_t t2CountHigh,
  input wire logic t3SplitSelect,
  input wire logic t3RunControl,
  input wire logic t3HighSysclockSelect,
  input wire logic t3LowSysclockSelect,
  input wire ltm_pkg::ltm_xclk_t t3AltClockField,
  input wire logic t3IrqEnable,
  input wire logic t3LowIrqEnable,
  input wire logic t3HighFlagClear,
  input wire logic t3LowFlagClear,
  output logic t3HighOverflowFlag,
  output logic t3LowOverflowFlag,
  output ltm_pkg::ltm_byte_t t3CountHigh,
  output logic t3IrqRequest
);
  import ltm_pkg::*;

  // ----------------------------------------------------------------
  // Clock enables
  // ----------------------------------------------------------------
  logic [3:0] div12Reg;
  logic [3:0] div12Next;
  logic [2:0] ext8Reg;
  logic [2:0] ext8Next;
  logic extPrevReg;
  logic slowSync1Reg;
  logic slowSync2Reg;
  logic slowPrevReg;
  logic div12Tick;
  logic extRise;
  logic ext8Tick;
  logic slowFall;

  assign div12Tick = (div12Reg == `LTM_DIV12_LAST);
  assign extRise = extOscIn & ~extPrevReg;
  assign ext8Tick = extRise & (ext8Reg == `LTM_EXT8_LAST);
  // Edge taken after the second stage only, never the first
  assign slowFall = slowPrevReg & ~slowSync2Reg;

  always_comb
  begin
    div12Next = div12Tick ? `LTM_DIV12_ZERO : div12Reg + `LTM_DIV12_ONE;
    ext8Next = ext8Reg;
    if (extRise)
    begin
      ext8Next = ext8Reg + `LTM_EXT8_ONE;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      div12Reg <= `LTM_DIV12_ZERO;
      ext8Reg <= `LTM_EXT8_ZERO;
      extPrevReg <= 1'b0;
      slowSync1Reg <= 1'b0;
      slowSync2Reg <= 1'b0;
      slowPrevReg <= 1'b0;
    end
    else
    begin
      div12Reg <= div12Next;
      ext8Reg <= ext8Next;
      extPrevReg <= extOscIn;
      slowSync1Reg <= slowOscIn;
      slowSync2Reg <= slowSync1Reg;
      slowPrevReg <= slowSync2Reg;
    end
  end

  // Reserved field code yields no ticks: the counter simply holds
  function automatic logic pickTick(input logic sysSel,
                                    input ltm_xclk_t field,
                                    input logic d12,
                                    input logic e8,
                                    input logic slow);
    logic t;
    t = 1'b0;
    if (sysSel)
      t = 1'b1;
    else
    begin
      case (field)
        LTM_XCLK_DIV12: t = d12;
        LTM_XCLK_EXT8: t = e8;
        LTM_XCLK_SLOW: t = slow;
        default: t = 1'b0;
      endcase
    end
    return t;
  endfunction

  // ----------------------------------------------------------------
  // Counter bytes
  // ----------------------------------------------------------------
  ltm_cnt_if t2Low();
  ltm_cnt_if t2High();
  ltm_cnt_if t3Low();
  ltm_cnt_if t3High();

  ltm_counter8 u_t2Low (.sys_clk(sys_clk), .reset_n(reset_n),
    .port(t2Low.cnt));
  ltm_counter8 u_t2High (.sys_clk(sys_clk), .reset_n(reset_n),
    .port(t2High.cnt));
  ltm_counter8 u_t3Low (.sys_clk(sys_clk), .reset_n(reset_n),
    .port(t3Low.cnt));
  ltm_counter8 u_t3High (.sys_clk(sys_clk), .reset_n(reset_n),
    .port(t3High.cnt));

  // ----------------------------------------------------------------
  // Register storage and flags
  // ----------------------------------------------------------------
  ltm_byte_t t2RelLowReg;
  ltm_byte_t t2RelLowNext;
  ltm_byte_t t2RelHighReg;
  ltm_byte_t t2RelHighNext;
  ltm_byte_t t3RelLowReg;
  ltm_byte_t t3RelLowNext;
  ltm_byte_t t3RelHighReg;
  ltm_byte_t t3RelHighNext;
  ltm_byte_t rdDataReg;
  ltm_byte_t rdDataNext;
  logic t2FlagReg;
  logic t2FlagNext;
  logic t3HighFlagReg;
  logic t3HighFlagNext;
  logic t3LowFlagReg;
  logic t3LowFlagNext;

  logic t2Tick;
  logic capMode;
  logic capEvent;
  logic t2_split_select;
  logic t2Wrap16;
  logic t2HighOvf;
  logic t3LowSrc;
  logic t3HighSrc;
  logic t3Wrap16;
  logic t3HighOvf;
  logic t3LowOvf;

  // ----------------------------------------------------------------
  // Timer 2
  // ----------------------------------------------------------------
  assign t2Tick = t2RunControl & (t2LowClockSelect ? 1'b1 :
    (t2AltClockSelect ? ext8Tick : div12Tick));
  assign capMode = t2CaptureEnable;
  assign capEvent = capMode & slowFall;
  // Capture needs the full count, so split is ignored while capturing
  assign t2_split_select = t2SplitSelect & ~capMode;
  assign t2Wrap16 = t2Low.atMax & t2High.atMax;

  always_comb
  begin
    t2Low.inc = t2Tick;
    t2Low.wrEn = sfrWrEn & (sfrAddr == `LTM_ADDR_T2_COUNT_LOW);
    t2Low.wrData = sfrWrData;
    t2Low.reloadVal = t2RelLowReg;
    t2High.wrEn = 1'b0;
    t2High.wrData = sfrWrData;
    t2High.reloadVal = t2RelHighReg;
    if (t2_split_select)
    begin
      t2High.inc = t2Tick;
      t2Low.reloadNow = t2Low.atMax;
      t2High.reloadNow = t2High.atMax;
    end
    else
    begin
      t2High.inc = t2Tick & t2Low.atMax;
      // Capture mode free-runs so successive captures difference cleanly
      t2Low.reloadNow = t2Wrap16 & ~capMode;
      t2High.reloadNow = t2Wrap16 & ~capMode;
    end
  end

  assign t2HighOvf = t2High.inc & t2High.atMax & ~capMode;

  // ----------------------------------------------------------------
  // Timer 3
  // ----------------------------------------------------------------
  assign t3HighSrc = pickTick(t3HighSysclockSelect, t3AltClockField,
    div12Tick, ext8Tick, slowFall);
  assign t3LowSrc = pickTick(t3LowSysclockSelect, t3AltClockField,
    div12Tick, ext8Tick, slowFall);
  assign t3Wrap16 = t3Low.atMax & t3High.atMax;

  always_comb
  begin
    t3Low.wrEn = sfrWrEn & (sfrAddr == `LTM_ADDR_T3_COUNT_LOW);
    t3Low.wrData = sfrWrData;
    t3Low.reloadVal = t3RelLowReg;
    t3High.wrEn = 1'b0;
    t3High.wrData = sfrWrData;
    t3High.reloadVal = t3RelHighReg;
    if (t3SplitSelect)
    begin
      t3Low.inc = t3LowSrc;
      t3High.inc = t3RunControl & t3HighSrc;
      t3Low.reloadNow = t3Low.atMax;
      t3High.reloadNow = t3High.atMax;
    end
    else
    begin
      t3Low.inc = t3RunControl & t3LowSrc;
      t3High.inc = t3RunControl & t3LowSrc & t3Low.atMax;
      t3Low.reloadNow = t3Wrap16;
      t3High.reloadNow = t3Wrap16;
    end
  end

  assign t3HighOvf = t3High.inc & t3High.atMax;
  assign t3LowOvf = t3SplitSelect & t3Low.inc & t3Low.atMax;

  // ----------------------------------------------------------------
  // Register port, reloads and flags
  // ----------------------------------------------------------------
  always_comb
  begin
    t2RelLowNext = t2RelLowReg;
    t2RelHighNext = t2RelHighReg;
    t3RelLowNext = t3RelLowReg;
    t3RelHighNext = t3RelHighReg;
    if (sfrWrEn)
    begin
      case (sfrAddr)
        `LTM_ADDR_T2_RELOAD_LOW: t2RelLowNext = sfrWrData;
        `LTM_ADDR_T2_RELOAD_HIGH: t2RelHighNext = sfrWrData;
        `LTM_ADDR_T3_RELOAD_LOW: t3RelLowNext = sfrWrData;
        `LTM_ADDR_T3_RELOAD_HIGH: t3RelHighNext = sfrWrData;
        default: ;
      endcase
    end
    // Hardware capture beats a software write in the same cycle
    if (capEvent)
    begin
      t2RelLowNext = t2Low.count;
      t2RelHighNext = t2High.count;
    end
    rdDataNext = rdDataReg;
    if (sfrRdEn)
    begin
      case (sfrAddr)
        `LTM_ADDR_T3_RELOAD_LOW: rdDataNext = t3RelLowReg;
        `LTM_ADDR_T3_RELOAD_HIGH: rdDataNext = t3RelHighReg;
        `LTM_ADDR_T3_COUNT_LOW: rdDataNext = t3Low.count;
        `LTM_ADDR_T2_RELOAD_LOW: rdDataNext = t2RelLowReg;
        `LTM_ADDR_T2_RELOAD_HIGH: rdDataNext = t2RelHighReg;
        `LTM_ADDR_T2_COUNT_LOW: rdDataNext = t2Low.count;
        default: rdDataNext = `LTM_UNMAPPED_READ;
      endcase
    end
    // Set wins over a clear arriving in the same cycle
    t2FlagNext = (t2FlagReg & ~t2HighFlagClear) | capEvent
      | t2HighOvf;
    t3HighFlagNext = (t3HighFlagReg & ~t3HighFlagClear)
      | t3HighOvf;
    t3LowFlagNext = (t3LowFlagReg & ~t3LowFlagClear)
      | t3LowOvf;
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      t2RelLowReg <= `LTM_RESET_BYTE;
      t2RelHighReg <= `LTM_RESET_BYTE;
      t3RelLowReg <= `LTM_RESET_BYTE;
      t3RelHighReg <= `LTM_RESET_BYTE;
      rdDataReg <= `LTM_RESET_BYTE;
      t2FlagReg <= 1'b0;
      t3HighFlagReg <= 1'b0;
      t3LowFlagReg <= 1'b0;
    end
    else
    begin
      t2RelLowReg <= t2RelLowNext;
      t2RelHighReg <= t2RelHighNext;
      t3RelLowReg <= t3RelLowNext;
      t3RelHighReg <= t3RelHighNext;
      rdDataReg <= rdDataNext;
      t2FlagReg <= t2FlagNext;
      t3HighFlagReg <= t3HighFlagNext;
      t3LowFlagReg <= t3LowFlagNext;
    end
  end

  assign sfrRdData = rdDataReg;
  assign t2HighFlag = t2FlagReg;
  assign t2CountHigh = t2High.count;
  assign t3CountHigh = t3High.count;
  assign t3HighOverflowFlag = t3HighFlagReg;
  assign t3LowOverflowFlag = t3LowFlagReg;
  // Level request; stays up until software clears the flag or its interrupt enable drops
  assign t3IrqRequest = t3IrqEnable & (t3HighFlagReg
    | (t3LowIrqEnable & t3LowFlagReg));

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);

  a_capture_copy : assert property (
    capEvent |=> t2RelLowReg == $past(t2Low.count)
      && t2RelHighReg == $past(t2High.count) && t2FlagReg)
    else $error("Capture did not copy count");

  a_one_capture : assert property (
    slowFall |=> !slowFall)
    else $error("Two captures for one edge");

  a_div12_period : assert property (
    div12Tick |-> ##12 div12Tick)
    else $error("Divide by twelve period wrong");

  a_t2_sys_tick : assert property (
    t2RunControl && t2LowClockSelect |-> t2Low.inc)
    else $error("Timer 2 missed system clock tick");

  a_t3_split_reload : assert property (
    t3SplitSelect && t3High.inc && t3High.atMax && !t3High.wrEn
      |=> t3High.count == $past(t3RelHighReg))
    else $error("High byte did not reload");

  a_t3_low_free : assert property (
    t3SplitSelect && t3LowSrc |-> t3Low.inc)
    else $error("Split low byte not counting");

  a_t3_high_stop : assert property (
    t3SplitSelect && !t3RunControl |-> !t3High.inc)
    else $error("High byte ran while stopped");

  a_t3_ovf_flag : assert property (
    t3SplitSelect && t3Low.inc && t3Low.atMax |=> t3LowFlagReg)
    else $error("Low overflow flag not set");

  a_t3_flag_sticky : assert property (
    t3HighFlagReg && !t3HighFlagClear |=> t3HighFlagReg)
    else $error("High flag cleared by hardware");

  a_t3_irq_high : assert property (
    t3IrqEnable && t3HighFlagReg |-> t3IrqRequest)
    else $error("Missing high overflow request");

  a_t3_irq_low : assert property (
    t3IrqEnable && t3LowIrqEnable && t3LowFlagReg |-> t3IrqRequest)
    else $error("Missing low overflow request");
endmodule

// ### testbench/ltm_osc_model.sv
// Oscillator pins that face the timer block: external and slow clocks.
// Assumes the timer samples both levels on its own system clock.
`timescale 1ns/1ps
module ltm_osc_model
#(
  parameter int EXT_HALF_NS = 50,
  parameter int SLOW_HALF_NS = 1200
)
(
  output logic extOsc,
  output logic slowOsc
);
  // --------------------------------------------------------------
  // Free-running sources
  // --------------------------------------------------------------
  // Slow period far above any timer tick, so captures resolve well
  initial
  begin
    slowOsc = 1'b1;
    forever #(SLOW_HALF_NS) slowOsc = ~slowOsc;
  end

  initial
  begin
    extOsc = 1'b0;
    forever #(EXT_HALF_NS) extOsc = ~extOsc;
  end
endmodule

// ### testbench/tb_top.sv
// Self-checking bench for the capture and split timer block.
// Assumes the package, interface and design files compile first.
`timescale 1ns/1ps
module tb_top;
  import ltm_pkg::*;
  logic sys_clk, reset_n, sfrWrEn, sfrRdEn, extOscIn, slowOscIn;
  ltm_byte_t sfrAddr, sfrWrData, sfrRdData, t2CountHigh, t3CountHigh;
  logic t2Run, t2Low, t2Alt, t2Cap, t2_split_select, t2Clr, t2Flag;
  logic t3_split_select, t3Run, t3HiSys, t3LoSys, t3Irq, t3LoIrq;
  logic t3HiClr, t3LoClr, t3HiFlag, t3LoFlag, t3IrqReq, rdLate;
  ltm_xclk_t t3Field;
  logic [8:0] notes[$];
  logic [8:0] note;
  ltm_byte_t addrs[6] = '{8'h92, 8'h93, 8'h94, 8'hca, 8'hcb, 8'hcc};
  int fails, samples_checked;

  ltm_timers uut
  (
    .sys_clk(sys_clk), .reset_n(reset_n), .sfrAddr(sfrAddr),
    .sfrWrEn(sfrWrEn), .sfrWrData(sfrWrData), .sfrRdEn(sfrRdEn),
    .sfrRdData(sfrRdData), .extOscIn(extOscIn), .slowOscIn(slowOscIn),
    .t2RunControl(t2Run), .t2LowClockSelect(t2Low),
    .t2AltClockSelect(t2Alt), .t2CaptureEnable(t2Cap),
    .t2SplitSelect(t2_split_select), .t2HighFlagClear(t2Clr),
    .t2HighFlag(t2Flag), .t2CountHigh(t2CountHigh),
    .t3SplitSelect(t3_split_select), .t3RunControl(t3Run),
    .t3HighSysclockSelect(t3HiSys), .t3LowSysclockSelect(t3LoSys),
    .t3AltClockField(t3Field), .t3IrqEnable(t3Irq),
    .t3LowIrqEnable(t3LoIrq), .t3HighFlagClear(t3HiClr),
    .t3LowFlagClear(t3LoClr), .t3HighOverflowFlag(t3HiFlag),
    .t3LowOverflowFlag(t3LoFlag), .t3CountHigh(t3CountHigh),
    .t3IrqRequest(t3IrqReq)
  );

  ltm_osc_model osc
  (
    .extOsc(extOscIn),
    .slowOsc(slowOscIn)
  );

  initial
  begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  // --------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("checked %0d, mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic wr(input ltm_byte_t a, input ltm_byte_t d);
    @(posedge sys_clk);
    sfrWrEn <= 1'b1;
    sfrAddr <= a;
    sfrWrData <= d;
    @(posedge sys_clk);
    sfrWrEn <= 1'b0;
  endtask

  // Note the expectation; the monitor compares when data lands
  task automatic rd(input ltm_byte_t a, input logic c, input ltm_byte_t e,
                    output ltm_byte_t v);
    @(posedge sys_clk);
    sfrRdEn <= 1'b1;
    sfrAddr <= a;
    notes.push_back({c, e});
    @(posedge sys_clk);
    sfrRdEn <= 1'b0;
    @(posedge sys_clk);
    v = sfrRdData;
  endtask

  always @(posedge sys_clk)
  begin
    if (rdLate === 1'b1 && notes.size() > 0)
    begin
      note = notes.pop_front();
      if (note[8])
        chk(16'(sfrRdData), 16'(note[7:0]));
    end
    rdLate <= sfrRdEn;
  end

  task automatic clr(input int w);
    @(posedge sys_clk);
    if (w == 2)
      t2Clr <= 1'b1;
    else if (w == 1)
      t3HiClr <= 1'b1;
    else
      t3LoClr <= 1'b1;
    @(posedge sys_clk);
    t2Clr <= 1'b0;
    t3HiClr <= 1'b0;
    t3LoClr <= 1'b0;
  endtask

  // Bounded wait on a flag, sampled at the falling edge
  task automatic waitHi(input int w, input int lim, output time t);
    int n;
    logic f;
    for (n = 0; n < lim; n++)
    begin
      @(negedge sys_clk);
      f = (w == 2) ? t2Flag : (w == 1) ? t3HiFlag : t3LoFlag;
      if (f === 1'b1)
        break;
    end
    if (n == lim)
    begin
      fails++;
      report_and_stop();
    end
    t = $time;
  endtask

  // First overflow may straddle a clock change, so it is discarded
  task automatic period(input int w, input int cyc);
    time a, b;
    clr(w);
    waitHi(w, 4000, a);
    clr(w);
    waitHi(w, 4000, a);
    clr(w);
    waitHi(w, 4000, b);
    chk(16'((b - a) / 25), 16'(cyc));
  endtask

  task automatic capDiff(input logic lo, input logic alt, input int exp);
    ltm_byte_t h, l;
    logic [15:0] v1;
    time t;
    @(posedge sys_clk);
    t2Low <= lo;
    t2Alt <= alt;
    clr(2);
    waitHi(2, 500, t);
    clr(2);
    waitHi(2, 500, t);
    rd(8'hcb, 1'b0, 8'h00, h);
    rd(8'hca, 1'b0, 8'h00, l);
    v1 = {h, l};
    clr(2);
    waitHi(2, 500, t);
    rd(8'hcb, 1'b0, 8'h00, h);
    rd(8'hca, 1'b0, 8'h00, l);
    chk({h, l} - v1, 16'(exp));
    clr(2);
    repeat (40) @(negedge sys_clk);
    chk(16'(t2Flag), 16'h0000);
  endtask

  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial
  begin
    ltm_byte_t v, d;
    time t;
    {reset_n, sfrWrEn, sfrRdEn, t2Run, t2Low, t2Alt, t2Cap} = '0;
    {t2_split_select, t2Clr, t3_split_select, t3Run, t3HiSys, t3LoSys, t3Irq} = '0;
    {t3LoIrq, t3HiClr, t3LoClr, rdLate} = '0;
    sfrAddr = 8'h00;
    sfrWrData = 8'h00;
    t3Field = LTM_XCLK_DIV12;
    fails = 0;
    samples_checked = 0;
    d = 8'($urandom(32'h864b));
    repeat (10) @(posedge sys_clk);
    reset_n <= 1'b1;
    foreach (addrs[i])
      rd(addrs[i], 1'b1, 8'h00, v);
    rd(8'h95, 1'b1, 8'h00, v);
    // Both timers stopped, so counts read back as written
    foreach (addrs[i])
    begin
      d = 8'($urandom);
      wr(addrs[i], d);
      rd(addrs[i], 1'b1, d, v);
    end
    @(posedge sys_clk);
    t3_split_select <= 1'b1;
    t3HiSys <= 1'b1;
    t3LoSys <= 1'b1;
    t3Irq <= 1'b1;
    wr(8'h92, 8'h10);
    wr(8'h93, 8'hf0);
    wr(8'h94, 8'hfd);
    waitHi(0, 20, t);
    chk(16'(t3IrqReq), 16'h0000);
    chk(16'(t3HiFlag), 16'h0000);
    chk(16'(t3CountHigh), 16'h0000);
    @(posedge sys_clk);
    t3LoIrq <= 1'b1;
    @(negedge sys_clk);
    chk(16'(t3IrqReq), 16'h0001);
    repeat (300) @(negedge sys_clk);
    chk(16'(t3LoFlag), 16'h0001);
    period(0, 240);
    @(posedge sys_clk);
    t3LoSys <= 1'b0;
    period(0, 2880);
    @(posedge sys_clk);
    t3LoSys <= 1'b1;
    t3Run <= 1'b1;
    period(1, 16);
    @(posedge sys_clk);
    t3HiSys <= 1'b0;
    period(1, 192);
    @(posedge sys_clk);
    t3Field <= LTM_XCLK_EXT8;
    period(1, 512);
    @(posedge sys_clk);
    t3Field <= LTM_XCLK_SLOW;
    period(1, 1536);
    @(posedge sys_clk);
    t3Field <= LTM_XCLK_RSVD;
    clr(1);
    d = t3CountHigh;
    repeat (600) @(negedge sys_clk);
    chk(16'(t3HiFlag), 16'h0000);
    chk(16'(t3CountHigh), 16'(d));
    // Low flag alone must not request while its own enable is off
    @(posedge sys_clk);
    t3LoIrq <= 1'b0;
    @(negedge sys_clk);
    chk(16'(t3LoFlag), 16'h0001);
    chk(16'(t3IrqReq), 16'h0000);
    @(posedge sys_clk);
    t3HiSys <= 1'b1;
    wr(8'h93, 8'hff);
    waitHi(1, 300, t);
    chk(16'(t3IrqReq), 16'h0001);
    // High byte parks at ff, then 16-bit mode wraps to reload pair
    repeat (40) @(negedge sys_clk);
    @(posedge sys_clk);
    t3_split_select <= 1'b0;
    clr(0);
    period(1, 240);
    chk(16'(t3LoFlag), 16'h0000);
    @(posedge sys_clk);
    t2_split_select <= 1'b0;
    t2Run <= 1'b1;
    t2Cap <= 1'b1;
    capDiff(1'b1, 1'b0, 96);
    capDiff(1'b0, 1'b0, 8);
    capDiff(1'b0, 1'b1, 3);
    // Timer 2 outside capture: split bytes first, then full 16-bit
    @(posedge sys_clk);
    t2Cap <= 1'b0;
    t2_split_select <= 1'b1;
    t2Low <= 1'b1;
    wr(8'hcb, 8'hf0);
    clr(2);
    waitHi(2, 400, t);
    chk(16'(t2CountHigh), 16'h00f0);
    period(2, 16);
    wr(8'hcb, 8'hff);
    repeat (40) @(negedge sys_clk);
    @(posedge sys_clk);
    t2_split_select <= 1'b0;
    wr(8'hcb, 8'hfe);
    wr(8'hca, 8'h00);
    period(2, 512);
    chk(16'(t2CountHigh), 16'h00fe);
    report_and_stop();
  end
endmodule
